// ---- hw/btr_branch_trace_recorder.sv ----
// Purpose: branch trace messages, branch traps and branch records of a core
// Assumes: event inputs come from core logic on the same clock
// Notes: one message held until the bus accepts it
// Notes on behaviour
// - system management interrupt entry emits a trace message when messaging is on
// - source field holds the address executing at the event, fresh every time
// - with messages and traps both enabled, only messages occur
// - last branch record holds source and destination of latest branch, exception, SMI or software interrupt
// - pre-exception record holds the last branch taken before latest exception or SMI
// - faulting call or software interrupt updates last record only
// - bus reinit marks the pre-exception record invalid
// - a concurrent cache line fill never alters the message being sent
`timescale 1ns/100ps
`include "btr_params.svh"
module btr_branch_trace_recorder
    import btr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic msg_enable,
    input wire logic trap_enable,
    input wire logic event_valid,
    input wire btr_event_t event_kind,
    input wire btr_addr_t event_source,
    input wire btr_addr_t event_dest,
    input wire logic bus_reinit_signal,
    input wire logic fill_valid,
    input wire btr_addr_t fill_data,
    output logic event_ready,
    output logic branch_trap,
    output logic msg_valid,
    input wire logic msg_ready,
    output btr_addr_t msg_source,
    output btr_addr_t msg_dest,
    output btr_event_t msg_kind,
    output btr_addr_t last_src,
    output btr_addr_t last_dst,
    output btr_addr_t pre_src,
    output btr_addr_t pre_dst,
    output logic pre_valid,
    output logic fill_done,
    output btr_addr_t fill_line
);
    // ------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------
    btr_state_t state_ff;
    btr_addr_t br_src_ff;
    btr_addr_t br_dst_ff;
    logic br_seen_ff;
    logic trap_ff;
    logic take;
    logic is_branch;
    logic is_exc;
    btr_addr_t msg_src_ff;
    btr_addr_t msg_dst_ff;
    btr_event_t msg_kind_ff;
    btr_addr_t last_src_ff;
    btr_addr_t last_dst_ff;
    btr_addr_t pre_src_ff;
    btr_addr_t pre_dst_ff;
    logic pre_valid_ff;
    logic fill_done_ff;
    btr_addr_t fill_line_ff;

    assign event_ready = (state_ff == BTR_ST_IDLE);
    assign take = event_valid && event_ready;
    assign is_branch = (event_kind == BTR_EV_BRANCH);
    assign is_exc = (event_kind == BTR_EV_EXCEPT) || (event_kind == BTR_EV_SMI);

    // ------------------------------------------------------------
    // message path
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= BTR_ST_IDLE;
        end else begin
            case (state_ff)
                BTR_ST_IDLE: begin
                    if (take && msg_enable) begin
                        state_ff <= BTR_ST_SEND;
                    end
                end
                BTR_ST_SEND: begin
                    if (msg_ready) begin
                        state_ff <= BTR_ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign msg_valid = (state_ff == BTR_ST_SEND);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msg_src_ff <= `BTR_ADDR_RST;
            msg_dst_ff <= `BTR_ADDR_RST;
            msg_kind_ff <= BTR_EV_BRANCH;
        end else if (take && msg_enable) begin
            msg_src_ff <= event_source;
            msg_dst_ff <= event_dest;
            msg_kind_ff <= event_kind;
        end
    end

    assign msg_source = msg_src_ff;
    assign msg_dest = msg_dst_ff;
    assign msg_kind = msg_kind_ff;

    // fill uses its own registers so it never collides with the message
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fill_line_ff <= `BTR_ADDR_RST;
            fill_done_ff <= 1'h0;
        end else begin
            fill_done_ff <= fill_valid;
            if (fill_valid) begin
                fill_line_ff <= fill_data;
            end
        end
    end

    assign fill_line = fill_line_ff;
    assign fill_done = fill_done_ff;

    // ------------------------------------------------------------
    // branch trap
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trap_ff <= 1'h0;
        end else begin
            trap_ff <= take && is_branch && trap_enable && !msg_enable;
        end
    end

    assign branch_trap = trap_ff;

    // ------------------------------------------------------------
    // branch records
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_src_ff <= `BTR_ADDR_RST;
            last_dst_ff <= `BTR_ADDR_RST;
        end else if (take) begin
            last_src_ff <= event_source;
            last_dst_ff <= event_dest;
        end
    end

    assign last_src = last_src_ff;
    assign last_dst = last_dst_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            br_src_ff <= `BTR_ADDR_RST;
            br_dst_ff <= `BTR_ADDR_RST;
            br_seen_ff <= 1'h0;
        end else if (take && is_branch) begin
            br_src_ff <= event_source;
            br_dst_ff <= event_dest;
            br_seen_ff <= 1'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_src_ff <= `BTR_ADDR_RST;
            pre_dst_ff <= `BTR_ADDR_RST;
            pre_valid_ff <= 1'h0;
        end else if (bus_reinit_signal) begin
            pre_valid_ff <= 1'h0;
        end else if (take && is_exc) begin
            pre_src_ff <= br_src_ff;
            pre_dst_ff <= br_dst_ff;
            pre_valid_ff <= br_seen_ff;
        end
    end

    assign pre_src = pre_src_ff;
    assign pre_dst = pre_dst_ff;
    assign pre_valid = pre_valid_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_take_msg;
        take && msg_enable;
    endsequence

    sequence s_take_smi;
        take && msg_enable && (event_kind == BTR_EV_SMI);
    endsequence

    sequence s_take_trap;
        take && is_branch && trap_enable && !msg_enable;
    endsequence

    sequence s_msg_wait;
        msg_valid && !msg_ready;
    endsequence

    sequence s_msg_accept;
        msg_valid && msg_ready;
    endsequence

    a_smi_message: assert property (@(posedge clock) disable iff (rst)
        s_take_smi |=> msg_valid && msg_kind == BTR_EV_SMI)
        else $error("smi entry gave no message");
    a_source_fresh: assert property (@(posedge clock) disable iff (rst)
        s_take_msg |=> msg_source == $past(event_source))
        else $error("message source stale");
    a_trap_excl: assert property (@(posedge clock) disable iff (rst)
        branch_trap |-> !$past(msg_enable) && $past(trap_enable))
        else $error("trap while messages on");
    a_trap_fire: assert property (@(posedge clock) disable iff (rst)
        s_take_trap |=> branch_trap)
        else $error("enabled branch gave no trap");
    a_last_update: assert property (@(posedge clock) disable iff (rst)
        take |=> last_src == $past(event_source) && last_dst == $past(event_dest))
        else $error("last record not updated");
    a_pre_capture: assert property (@(posedge clock) disable iff (rst)
        take && is_exc && !bus_reinit_signal |=>
            pre_src == $past(br_src_ff) && pre_dst == $past(br_dst_ff))
        else $error("pre record wrong");
    a_swint_keep: assert property (@(posedge clock) disable iff (rst)
        take && event_kind == BTR_EV_SWINT |=> $stable(pre_src) && $stable(pre_dst))
        else $error("software interrupt moved pre record");
    a_reinit_inval: assert property (@(posedge clock) disable iff (rst)
        bus_reinit_signal |=> !pre_valid)
        else $error("pre record valid after reinit");
    a_msg_hold: assert property (@(posedge clock) disable iff (rst)
        s_msg_wait |=> msg_valid && $stable(msg_source) && $stable(msg_dest)
            && $stable(msg_kind))
        else $error("message changed while waiting");
    a_fill_store: assert property (@(posedge clock) disable iff (rst)
        fill_valid |=> fill_done && fill_line == $past(fill_data))
        else $error("fill line not stored");
    a_one_write: assert property (@(posedge clock) disable iff (rst)
        s_msg_accept |=> !msg_valid)
        else $error("message written twice");
    a_quiet_off: assert property (@(posedge clock) disable iff (rst)
        take && !msg_enable |=> !msg_valid)
        else $error("message while messaging off");
endmodule

// ---- hw/btr_params.svh ----
// Purpose: constants for the branch trace recorder
// Assumes: 32-bit instruction addresses
// Notes: definitions only
`ifndef BTR_PARAMS_SVH
`define BTR_PARAMS_SVH
`define BTR_ADDR_W 32
`define BTR_KIND_W 2
`define BTR_ADDR_RST 32'h0000_0000
`endif

// ---- hw/btr_pkg.sv ----
// Purpose: types for the branch trace recorder
// Assumes: btr_params.svh included first
// Notes: none
`include "btr_params.svh"
package btr_pkg;
    typedef logic [`BTR_ADDR_W-1:0] btr_addr_t;
    typedef enum logic [`BTR_KIND_W-1:0] {
        BTR_EV_BRANCH = 2'b00,
        BTR_EV_EXCEPT = 2'b01,
        BTR_EV_SMI    = 2'b10,
        BTR_EV_SWINT  = 2'b11
    } btr_event_t;
    typedef enum logic [0:0] {
        BTR_ST_IDLE = 1'b0,
        BTR_ST_SEND = 1'b1
    } btr_state_t;
endpackage

// ---- dv/btr_bus_agent.sv ----
// Purpose: system bus agent that captures trace messages
// Assumes: stall holds off acceptance
// Notes: counts every accepted message
`timescale 1ns/100ps
module btr_bus_agent
    import btr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic stall,
    input wire logic msg_valid,
    input wire btr_addr_t msg_source,
    input wire btr_addr_t msg_dest,
    input wire btr_event_t msg_kind,
    output logic msg_ready,
    output btr_addr_t got_src_ff,
    output btr_addr_t got_dst_ff,
    output btr_event_t got_kind_ff,
    output logic [7:0] got_cnt_ff
);
    assign msg_ready = msg_valid && !stall;
    // one capture per accepted write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            got_src_ff <= 32'h0;
            got_dst_ff <= 32'h0;
            got_kind_ff <= BTR_EV_BRANCH;
            got_cnt_ff <= 8'h0;
        end else if (msg_valid && msg_ready) begin
            got_src_ff <= msg_source;
            got_dst_ff <= msg_dest;
            got_kind_ff <= msg_kind;
            got_cnt_ff <= got_cnt_ff + 8'h1;
        end
    end
endmodule

// ---- dv/btr_branch_trace_recorder_tb_top.sv ----
// Purpose: self-checking bench of the branch trace recorder
// Assumes: bus agent answers at once unless stalled
// Notes: none
`timescale 1ns/100ps
module btr_branch_trace_recorder_tb_top
    import btr_pkg::*;
;
    logic clock = 1'h0, rst = 1'h1, msg_enable = 1'h0, trap_enable = 1'h0;
    logic event_valid = 1'h0, bus_reinit_signal = 1'h0, fill_valid = 1'h0, stall = 1'h0;
    btr_event_t event_kind = BTR_EV_BRANCH;
    btr_addr_t event_source = 32'h0, event_dest = 32'h0, fill_data = 32'h0;
    logic event_ready, branch_trap, msg_valid, msg_ready, pre_valid, fill_done;
    btr_addr_t msg_source, msg_dest, last_src, last_dst, pre_src, pre_dst, fill_line;
    btr_addr_t got_src_ff, got_dst_ff;
    btr_event_t msg_kind, got_kind_ff;
    logic [7:0] got_cnt_ff;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    always #5 clock = ~clock;
    btr_branch_trace_recorder i_btr_branch_trace_recorder (.clock, .rst, .msg_enable,
        .trap_enable, .event_valid, .event_kind, .event_source, .event_dest,
        .bus_reinit_signal, .fill_valid, .fill_data, .event_ready, .branch_trap, .msg_valid,
        .msg_ready, .msg_source, .msg_dest, .msg_kind, .last_src, .last_dst, .pre_src,
        .pre_dst, .pre_valid, .fill_done, .fill_line);
    btr_bus_agent i_btr_bus_agent (.clock, .rst, .stall, .msg_valid, .msg_source, .msg_dest,
        .msg_kind, .msg_ready, .got_src_ff, .got_dst_ff, .got_kind_ff, .got_cnt_ff);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task send(input btr_event_t k, input logic [31:0] s, input logic [31:0] d);
        @(posedge clock);
        event_valid <= 1'h1;
        event_kind <= k;
        event_source <= s;
        event_dest <= d;
        @(negedge clock);
        while (!event_ready) begin
            @(negedge clock);
        end
        @(posedge clock);
        event_valid <= 1'h0;
        #1;
    endtask
    task t_trap;
        trap_enable <= 1'h1;
        send(BTR_EV_BRANCH, 32'h1000, 32'h2000);
        chk("trap", branch_trap, 1'h1);
        chk("last_src", last_src, 32'h1000);
        chk("last_dst", last_dst, 32'h2000);
        @(posedge clock);
        msg_enable <= 1'h1;
        send(BTR_EV_BRANCH, 32'h1100, 32'h2100);
        chk("trap_off", branch_trap, 1'h0);
        chk("msg_valid", msg_valid, 1'h1);
    endtask
    task t_smi;
        send(BTR_EV_BRANCH, 32'h3000, 32'h4000);
        send(BTR_EV_SMI, 32'h5000, 32'h6000);
        @(posedge clock);
        #1;
        chk("smi_src", got_src_ff, 32'h5000);
        chk("smi_dst", got_dst_ff, 32'h6000);
        chk("smi_kind", got_kind_ff, BTR_EV_SMI);
        chk("count", got_cnt_ff, 8'h3);
    endtask
    task t_records;
        @(posedge clock);
        msg_enable <= 1'h0;
        send(BTR_EV_BRANCH, 32'h7000, 32'h7100);
        send(BTR_EV_EXCEPT, 32'h7200, 32'h7300);
        chk("pre_src", pre_src, 32'h7000);
        chk("pre_dst", pre_dst, 32'h7100);
        chk("pre_valid", pre_valid, 1'h1);
        send(BTR_EV_SWINT, 32'h7400, 32'h7500);
        chk("sw_last", last_src, 32'h7400);
        chk("sw_last_dst", last_dst, 32'h7500);
        chk("sw_pre", pre_src, 32'h7000);
        chk("sw_pre_dst", pre_dst, 32'h7100);
        @(posedge clock);
        bus_reinit_signal <= 1'h1;
        @(posedge clock);
        bus_reinit_signal <= 1'h0;
        #1;
        chk("reinit", pre_valid, 1'h0);
        chk("reinit_src", pre_src, 32'h7000);
    endtask
    task t_fill;
        @(posedge clock);
        msg_enable <= 1'h1;
        stall <= 1'h1;
        send(BTR_EV_BRANCH, 32'h8000, 32'h8100);
        @(posedge clock);
        fill_valid <= 1'h1;
        fill_data <= 32'h5a5a;
        @(posedge clock);
        fill_valid <= 1'h0;
        #1;
        chk("fill_done", fill_done, 1'h1);
        chk("fill_line", fill_line, 32'h5a5a);
        chk("held_src", msg_source, 32'h8000);
        chk("busy", event_ready, 1'h0);
        @(posedge clock);
        stall <= 1'h0;
        @(posedge clock);
        #1;
        chk("sent_src", got_src_ff, 32'h8000);
        chk("sent_cnt", got_cnt_ff, 8'h4);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            end_sim;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        t_trap;
        t_smi;
        t_records;
        t_fill;
        end_sim;
    end
endmodule
